// ### src/sfea_regs.vh
// register offsets, field positions and reset values of the fault aggregator
`ifndef SFEA_REGS_VH
`define SFEA_REGS_VH
`define SFEA_A_CORE_UV     8'h10
`define SFEA_A_CMP         8'h11
`define SFEA_A_CTRL        8'h12
`define SFEA_A_SUMMARY     8'h13
`define SFEA_A_FLAG_LO     8'h14
`define SFEA_A_FLAG_HI     8'h15
`define SFEA_A_EN_LO       8'h16
`define SFEA_A_EN_HI       8'h17
`define SFEA_SUMMARY_BIT   2
`define SFEA_CTRL_PIN_EN   0
`define SFEA_CTRL_PIN_LVL  1
`define SFEA_CORE_UV_RST   2'h0
`define SFEA_CORE_UV_SET   2'h3
`define SFEA_CMP_RST       3'h7
`define SFEA_CMP_CORE      2
`define SFEA_CMP_V18       0
`define SFEA_CMP_VIO       1
`define SFEA_EN_RST        16'h7eff
`define SFEA_CTRL_RST      1'h1
`define SFEA_F_DEC_A       0
`define SFEA_F_DEC_B       1
`define SFEA_F_IDLE        2
`define SFEA_F_LINE        3
`define SFEA_F_VIDRX       4
`define SFEA_F_REMOTE      5
`define SFEA_F_WMARK       6
`define SFEA_F_PKTCNT      7
`define SFEA_F_RETX        8
`define SFEA_F_RETXMAX     9
`define SFEA_F_MEM         10
`define SFEA_F_CORE        11
`define SFEA_F_CMP         12
`define SFEA_F_AUDIO       13
`define SFEA_F_OV          14
`define SFEA_NFLAG         16
`endif

// ### src/sfea_aggregator.v
// supply fault latching and error pin aggregation
`timescale 1ns/10ps
`default_nettype none
`include "sfea_regs.vh"
// Contract
// RULE_01: core undervoltage holds core logic in reset until the supply recovers.
// RULE_02: core undervoltage sets both core undervoltage status bits high, sticky.
// RULE_03: core undervoltage latches comparator status bit 2 low until cleared.
// RULE_04: those status bits survive the core reset; only power-on clears them. Code also clears them on a read of 0x10 or 0x11 once the fault is gone.
// RULE_05: host reads core status, then core fault flag; flag clears on read.
// RULE_06: supply-compare flag clears the same way: status read first, flag next.
// RULE_07: 1.8V undervoltage latches comparator bit 0 low, raises compare flag.
// RULE_08: I/O undervoltage latches comparator bit 1 low, raises compare flag.
// RULE_09: I/O supply has undervoltage detection only, no overvoltage.
// RULE_10: each set supply report enable lets its flag pull the pin low.
// RULE_11: pin flags latch, persist after the condition, clear when read.
// RULE_12: overvoltage flag can only set while the video path is active.
// RULE_13: active-low pin is NOR of all flags gated by report enables.
// RULE_14: most report enables default high after reset.
// RULE_15: summary bit 2 of 0x13 shows any error; pin enabled by default. Code shows only flags whose report enable is set.
// RULE_16: sources cover link, idle, line, video, remote, retransmit, memory, supply.
// RULE_17: line-fault interrupt asserts when either line-fault monitor reports.
// RULE_18: audio pattern flag asserts on nonzero error count while test runs.
// RULE_19: a bit read while its fault persists is set again next cycle.
module sfea_aggregator #(
   parameter ACNT_W = 8
) (
   input  wire              i_clk,
   input  wire              i_rst_n,
   input  wire              i_core_uv,
   input  wire              i_v18_uv,
   input  wire              i_vio_uv,
   input  wire              i_ov_event,
   input  wire              i_video_active,
   input  wire              i_link_a_decode_fault,
   input  wire              i_link_b_decode_fault,
   input  wire              i_idle_word_fault,
   input  wire [1:0]        i_line_fault_mon,
   input  wire              i_video_rx_irq,
   input  wire              i_remote_side_fault,
   input  wire              i_watermark_fault,
   input  wire              i_packet_count_fault,
   input  wire              i_retransmit_event,
   input  wire              i_retransmit_limit_event,
   input  wire              i_memory_fault,
   input  wire              i_audio_test_run,
   input  wire [ACNT_W-1:0] i_audio_err_cnt,
   input  wire              i_reg_rd,
   input  wire              i_reg_wr,
   input  wire [7:0]        i_reg_addr,
   input  wire [7:0]        i_reg_wdata,
   input  wire              i_fault_out_n_in,
   output reg  [7:0]        o_reg_rdata,
   output wire              o_fault_out_n_o,
   output wire              o_fault_out_n_oe,
   output reg               o_core_rst_n
);

   // analog comparators and the pin are asynchronous
   reg  [2:0] uv_meta_q;
   reg  [2:0] uv_sync_q;
   reg        ov_meta_q;
   reg        ov_sync_q;
   reg        pin_meta_q;
   reg        pin_sync_q;

   reg  [1:0]              core_uv_status_q;
   reg  [1:0]              core_uv_status_d;
   reg  [2:0]              comparator_status_q;
   reg  [2:0]              comparator_status_d;
   reg  [`SFEA_NFLAG-1:0]  flag_q;
   reg  [`SFEA_NFLAG-1:0]  flag_d;
   reg  [`SFEA_NFLAG-1:0]  report_enable_q;
   reg                     pin_en_q;
   reg  [`SFEA_NFLAG-1:0]  src;
   reg  [`SFEA_NFLAG-1:0]  rd_clr;
   reg  [7:0]              rdata_d;

   wire core_uv_s;
   wire v18_uv_s;
   wire vio_uv_s;
   wire line_fault_irq;
   wire audio_pattern_check_fault;
   wire any_fault;

   function hit;
      input       stb;
      input [7:0] addr;
      input [7:0] match;
      begin
         hit = stb & (addr == match);
      end
   endfunction

   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         uv_meta_q  <= 3'h0;
         uv_sync_q  <= 3'h0;
         ov_meta_q  <= 1'h0;
         ov_sync_q  <= 1'h0;
         pin_meta_q <= 1'h1;
         pin_sync_q <= 1'h1;
      end else begin
         uv_meta_q  <= {i_vio_uv, i_v18_uv, i_core_uv};
         uv_sync_q  <= uv_meta_q;
         ov_meta_q  <= i_ov_event;
         ov_sync_q  <= ov_meta_q;
         pin_meta_q <= i_fault_out_n_in;
         pin_sync_q <= pin_meta_q;
      end
   end

   assign core_uv_s = uv_sync_q[0];
   assign v18_uv_s  = uv_sync_q[1];
   assign vio_uv_s  = uv_sync_q[2];

   assign line_fault_irq = |i_line_fault_mon; // RULE_17
   assign audio_pattern_check_fault = i_audio_test_run &
                                      (i_audio_err_cnt != {ACNT_W{1'b0}}); // RULE_18

   // retained status: set beats the read clear
   always @* begin
      core_uv_status_d = core_uv_status_q;
      if (hit(i_reg_rd, i_reg_addr, `SFEA_A_CORE_UV)) begin
         core_uv_status_d = `SFEA_CORE_UV_RST; // RULE_05
      end
      if (core_uv_s) begin
         core_uv_status_d = `SFEA_CORE_UV_SET; // RULE_02 RULE_19
      end
   end

   always @* begin
      comparator_status_d = comparator_status_q;
      if (hit(i_reg_rd, i_reg_addr, `SFEA_A_CMP)) begin
         comparator_status_d = `SFEA_CMP_RST; // RULE_06
      end
      if (core_uv_s) begin
         comparator_status_d[`SFEA_CMP_CORE] = 1'b0; // RULE_03
      end
      if (v18_uv_s) begin
         comparator_status_d[`SFEA_CMP_V18] = 1'b0; // RULE_07
      end
      if (vio_uv_s) begin
         comparator_status_d[`SFEA_CMP_VIO] = 1'b0; // RULE_08 RULE_19
      end
   end

   // lives on the 1.8V domain: core undervoltage does not clear it
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         core_uv_status_q    <= `SFEA_CORE_UV_RST;
         comparator_status_q <= `SFEA_CMP_RST;
      end else begin
         core_uv_status_q    <= core_uv_status_d; // RULE_04
         comparator_status_q <= comparator_status_d; // RULE_04
      end
   end

   always @* begin
      src = {`SFEA_NFLAG{1'b0}}; // RULE_16
      src[`SFEA_F_DEC_A]   = i_link_a_decode_fault;
      src[`SFEA_F_DEC_B]   = i_link_b_decode_fault;
      src[`SFEA_F_IDLE]    = i_idle_word_fault;
      src[`SFEA_F_LINE]    = line_fault_irq;
      src[`SFEA_F_VIDRX]   = i_video_rx_irq;
      src[`SFEA_F_REMOTE]  = i_remote_side_fault;
      src[`SFEA_F_WMARK]   = i_watermark_fault;
      src[`SFEA_F_PKTCNT]  = i_packet_count_fault;
      src[`SFEA_F_RETX]    = i_retransmit_event;
      src[`SFEA_F_RETXMAX] = i_retransmit_limit_event;
      src[`SFEA_F_MEM]     = i_memory_fault;
      // held while status bits remain, so status must be read first
      src[`SFEA_F_CORE]    = |core_uv_status_q; // RULE_05
      src[`SFEA_F_CMP]     = comparator_status_q != `SFEA_CMP_RST; // RULE_06
      src[`SFEA_F_AUDIO]   = audio_pattern_check_fault;
      // vio overvoltage has no monitor, so only one ov input exists
      src[`SFEA_F_OV]      = ov_sync_q & i_video_active; // RULE_12 RULE_09
   end

   always @* begin
      rd_clr = {`SFEA_NFLAG{1'b0}};
      if (hit(i_reg_rd, i_reg_addr, `SFEA_A_FLAG_LO)) begin
         rd_clr[7:0] = 8'hff;
      end
      if (hit(i_reg_rd, i_reg_addr, `SFEA_A_FLAG_HI)) begin
         rd_clr[15:8] = 8'hff;
      end
      flag_d = (flag_q & ~rd_clr) | src; // RULE_11 RULE_19
   end

   assign any_fault = |(flag_q & report_enable_q); // RULE_10 RULE_13

   always @* begin
      rdata_d = 8'h00;
      if (i_reg_addr == `SFEA_A_CORE_UV) begin
         rdata_d = {6'h00, core_uv_status_q};
      end else if (i_reg_addr == `SFEA_A_CMP) begin
         rdata_d = {5'h00, comparator_status_q};
      end else if (i_reg_addr == `SFEA_A_CTRL) begin
         rdata_d[`SFEA_CTRL_PIN_EN]  = pin_en_q;
         rdata_d[`SFEA_CTRL_PIN_LVL] = pin_sync_q;
      end else if (i_reg_addr == `SFEA_A_SUMMARY) begin
         rdata_d[`SFEA_SUMMARY_BIT] = any_fault; // RULE_15
      end else if (i_reg_addr == `SFEA_A_FLAG_LO) begin
         rdata_d = flag_q[7:0];
      end else if (i_reg_addr == `SFEA_A_FLAG_HI) begin
         rdata_d = flag_q[15:8];
      end else if (i_reg_addr == `SFEA_A_EN_LO) begin
         rdata_d = report_enable_q[7:0];
      end else if (i_reg_addr == `SFEA_A_EN_HI) begin
         rdata_d = report_enable_q[15:8];
      end
   end

   // core-powered logic: held at its reset values while the core supply is low
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         flag_q          <= {`SFEA_NFLAG{1'b0}};
         report_enable_q <= `SFEA_EN_RST; // RULE_14
         pin_en_q        <= `SFEA_CTRL_RST; // RULE_15
         o_reg_rdata     <= 8'h00;
         o_core_rst_n    <= 1'b0;
      end else if (core_uv_s) begin
         flag_q          <= {`SFEA_NFLAG{1'b0}}; // RULE_01
         report_enable_q <= `SFEA_EN_RST;
         pin_en_q        <= `SFEA_CTRL_RST;
         o_reg_rdata     <= 8'h00;
         o_core_rst_n    <= 1'b0; // RULE_01
      end else begin
         o_core_rst_n <= 1'b1;
         flag_q       <= flag_d;
         if (i_reg_rd) begin
            o_reg_rdata <= rdata_d;
         end
         if (hit(i_reg_wr, i_reg_addr, `SFEA_A_EN_LO)) begin
            report_enable_q[7:0] <= i_reg_wdata;
         end
         if (hit(i_reg_wr, i_reg_addr, `SFEA_A_EN_HI)) begin
            report_enable_q[15:8] <= i_reg_wdata & 8'h7f;
         end
         if (hit(i_reg_wr, i_reg_addr, `SFEA_A_CTRL)) begin
            pin_en_q <= i_reg_wdata[`SFEA_CTRL_PIN_EN];
         end
      end
   end

   // open drain: only ever pulls low
   assign o_fault_out_n_o  = 1'b0;
   assign o_fault_out_n_oe = any_fault & pin_en_q; // RULE_13

endmodule
`default_nettype wire

// ### tb/sfea_properties.sv
// port assertions for the supply fault aggregator
`timescale 1ns/10ps
`default_nettype none
`include "sfea_regs.vh"
module sfea_props #(
   parameter ACNT_W = 8
) (
   input wire logic              i_clk,
   input wire logic              i_rst_n,
   input wire logic              i_core_uv,
   input wire logic [1:0]        i_line_fault_mon,
   input wire logic              i_audio_test_run,
   input wire logic [ACNT_W-1:0] i_audio_err_cnt,
   input wire logic              i_reg_rd,
   input wire logic              i_reg_wr,
   input wire logic [7:0]        i_reg_addr,
   input wire logic [7:0]        o_reg_rdata,
   input wire logic              o_fault_out_n_o,
   input wire logic              o_fault_out_n_oe,
   input wire logic              o_core_rst_n
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   // the comparator is synced over two flops, so look three cycles back
   sequence quiet; (!i_core_uv) [*3]; endsequence
   sequence rd_of(a); i_reg_rd && i_reg_addr == a; endsequence
   pin_drive_a:
      assert property (!o_fault_out_n_o) else $error("pin driven high");
   uv_hold_a:
      assert property (i_core_uv [*5] |-> !o_core_rst_n)
      else $error("core not held in reset");
   uv_free_a:
      assert property ((!i_core_uv) [*5] |-> o_core_rst_n)
      else $error("core reset not released");
   rd_hold_a:
      assert property (quiet ##0 !i_reg_rd |=> $stable(o_reg_rdata))
      else $error("read data moved without a read");
   flag_keep_a:
      assert property (quiet ##0 (o_fault_out_n_oe && !i_reg_rd && !i_reg_wr)
         |=> o_fault_out_n_oe) else $error("pin released on its own");
   summary_a:
      assert property (quiet ##0 rd_of(`SFEA_A_SUMMARY) ##0 o_fault_out_n_oe
         |=> o_reg_rdata[`SFEA_SUMMARY_BIT]) else $error("summary bit low");
   line_flag_a:
      assert property (quiet ##0 (|i_line_fault_mon) ##2 rd_of(`SFEA_A_FLAG_LO)
         |=> o_reg_rdata[3]) else $error("line flag missing");
   audio_flag_a:
      assert property (quiet ##0 (i_audio_test_run && |i_audio_err_cnt)
         ##2 rd_of(`SFEA_A_FLAG_HI) |=> o_reg_rdata[5])
      else $error("audio flag missing");
endmodule
`default_nettype wire

// ### tb/sfea_host_model.sv
// open-drain error line with its pull-up, as the host sees it
`timescale 1ns/10ps
`default_nettype none
module sfea_host_model (
   input  wire logic i_drv_o,
   input  wire logic i_drv_oe,
   output wire logic o_pin
);
   // released line floats up, never keeps the last driven level
   assign o_pin = i_drv_oe ? i_drv_o : 1'b1;
endmodule
`default_nettype wire

// ### tb/testbench.sv
// self-checking bench for the supply fault aggregator
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
   err_count++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module testbench;
   logic        i_clk = 0, i_rst_n = 0, rd = 0, wr = 0, cu = 0, v18 = 0;
   logic        vio = 0, ov = 0, vid = 0, run = 0;
   logic [10:0] s = 0;
   logic [1:0]  lm = 0;
   logic [7:0]  ad = 0, wd = 0, acnt = 0, d;
   logic [31:0] r = 32'h8c3f173c;
   wire         pin, po, poe, crst;
   wire  [7:0]  rdat;
   int          mf = 0, en = 'h7eff, pe = 1, cuv = 0, cmp = 7;
   int          err_count = 0, comparisons = 0;
   int          ra[] = '{'h10, 'h11, 'h12, 'h13, 'h14, 'h15, 'h16, 'h17, 'h00};
   always #4 i_clk = ~i_clk;
   sfea_aggregator #(.ACNT_W(8)) dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_core_uv(cu), .i_v18_uv(v18), .i_vio_uv(vio), .i_ov_event(ov),
      .i_video_active(vid), .i_link_a_decode_fault(s[0]),
      .i_link_b_decode_fault(s[1]), .i_idle_word_fault(s[2]),
      .i_line_fault_mon(lm), .i_video_rx_irq(s[4]),
      .i_remote_side_fault(s[5]), .i_watermark_fault(s[6]),
      .i_packet_count_fault(s[7]), .i_retransmit_event(s[8]),
      .i_retransmit_limit_event(s[9]), .i_memory_fault(s[10]),
      .i_audio_test_run(run), .i_audio_err_cnt(acnt), .i_reg_rd(rd),
      .i_reg_wr(wr), .i_reg_addr(ad), .i_reg_wdata(wd),
      .i_fault_out_n_in(pin), .o_reg_rdata(rdat), .o_fault_out_n_o(po),
      .o_fault_out_n_oe(poe), .o_core_rst_n(crst));
   sfea_host_model host (.i_drv_o(po), .i_drv_oe(poe), .o_pin(pin));
   function logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function int pexp();
      return !((mf & en) != 0 && pe != 0);
   endfunction
   function int mx(input int a);
      case (a)
         'h10: return cuv;
         'h11: return cmp;
         'h12: return pexp() * 2 + pe;
         'h13: return ((mf & en) != 0) * 4;
         'h14: return mf & 'hff;
         'h15: return mf >> 8;
         'h16: return en & 'hff;
         'h17: return en >> 8;
         default: return 0;
      endcase
   endfunction
   task tally_and_finish;
      $display("checks %0d errors %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task rf(input int a);
      int e;
      e = mx(a);
      @(posedge i_clk);
      rd <= 1;
      ad <= 8'(a);
      #1 `CHK("pin", pexp(), pin)
      @(posedge i_clk);
      rd <= 0;
      #1 d = rdat;
      `CHK("rdata", e, d)
      if (a == 'h10) cuv = 0;
      if (a == 'h11) cmp = 7;
      if (a == 'h14) mf &= 'hff00;
      if (a == 'h15) mf &= 'hff;
      // status still showing a fault puts the flag straight back
      if (cuv != 0) mf |= 'h800;
      if (cmp != 7) mf |= 'h1000;
   endtask
   task wf(input int a, input int v);
      @(posedge i_clk);
      wr <= 1;
      ad <= 8'(a);
      wd <= 8'(v);
      @(posedge i_clk);
      wr <= 0;
      if (a == 'h12) pe = v & 1;
      if (a == 'h16) en = (en & 'hff00) | v;
   endtask
   // index 0-10 same-clock sources, 12/15 supplies, 13 audio, 14 overvoltage
   task ev(input int i, input int n);
      @(posedge i_clk);
      r = lfsr(r);
      s <= 11'(1 << i);
      lm <= (i == 3) ? 2'(1 + r[0]) : 2'h0;
      acnt <= r[7:0] | 8'h01;
      {run, ov, v18, vio} <= {i == 13, i == 14, i == 12, i == 15};
      repeat (n) @(posedge i_clk);
      {s, lm, run, ov, v18, vio} <= '0;
      // let the two-flop comparator sync drain before any read
      repeat (3) @(posedge i_clk);
      if (i < 11 || i == 13 || (i == 14 && vid)) mf |= 1 << i;
      if (i == 12 || i == 15) begin
         cmp &= (i == 12) ? 6 : 5;
         mf |= 'h1000;
      end
   endtask
   // one-cycle source pulse read two cycles later
   task pulse(input int a);
      @(posedge i_clk);
      r = lfsr(r);
      lm <= (a == 'h14) ? 2'(1 + r[0]) : 2'h0;
      run <= a == 'h15;
      acnt <= r[7:0] | 8'h01;
      @(posedge i_clk);
      {lm, run} <= '0;
      mf |= (a == 'h14) ? 'h8 : 'h2000;
      rf(a);
   endtask
   initial begin
      repeat (5000) @(posedge i_clk);
      err_count++;
      tally_and_finish;
   end
   initial begin
      repeat (10) @(posedge i_clk);
      i_rst_n <= 1;
      repeat (2) @(posedge i_clk);
      foreach (ra[k]) rf(ra[k]);
      for (int i = 0; i < 16; i++) begin
         ev(i, 4);
         rf(i < 8 ? 'h14 : 'h15);
         rf('h13);
         if (i == 12 || i == 15) rf('h11);
         rf('h15);
         rf('h14);
      end
      pulse('h14);
      pulse('h15);
      vid <= 1;
      ev(14, 4);
      rf('h15);
      wf('h12, 0);
      ev(10, 1);
      rf('h13);
      wf('h12, 1);
      rf('h13);
      rf('h12);
      wf('h13, 'hff);
      wf('h16, 0);
      rf('h16);
      rf('h15);
      @(posedge i_clk);
      cu <= 1;
      repeat (8) @(posedge i_clk);
      @(negedge i_clk) `CHK("core_rst_n", 0, crst)
      {mf, en, pe, cuv} = {32'h0, 32'h7eff, 32'h1, 32'h3};
      cmp &= 3;
      @(posedge i_clk);
      cu <= 0;
      repeat (8) @(posedge i_clk);
      @(negedge i_clk) `CHK("core_rst_n", 1, crst)
      mf = 'h1800;
      rf('h16);
      rf('h15);
      rf('h10);
      rf('h11);
      rf('h15);
      rf('h15);
      tally_and_finish;
   end
endmodule
bind sfea_aggregator sfea_props #(.ACNT_W(ACNT_W)) u_props (.*);
`default_nettype wire
